// File: hdl/ira_pkg.sv
`default_nettype none

// -----------------------------------------------------------------------------
// Shared constants of the register access slave.
// -----------------------------------------------------------------------------
package ira_pkg;

  // Widths of the index pointer, the data bytes and the storage address.
  localparam int IDX_W = 7;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 4;

  // Fixed upper five bits of the seven-bit slave address (binary 10011).
  localparam logic [4:0] SLAVE_PREFIX = 5'h13;

  // Index pointer value after reset.
  localparam logic [6:0] IDX_RESET = 7'h00;

  // Read window: any index in this range answers with a data byte.
  localparam logic [6:0] RD_WIN_LO = 7'h10;
  localparam logic [6:0] RD_WIN_HI = 7'h1F;

  // Writable mode registers; a write elsewhere is not acknowledged.
  localparam logic [6:0] WR_LO = 7'h10;
  localparam logic [6:0] WR_HI = 7'h15;

  // Read-only index that returns the two zero flags.
  localparam logic [6:0] FLAG_IDX = 7'h16;

  // Value of each stored mode register after reset.
  localparam logic [7:0] MEM_RESET = 8'h00;

  // Value read back outside the read window.
  localparam logic [7:0] RD_OUTSIDE = 8'h00;

  // Suppressor timing: period of the sampling clock and longest spike.
  localparam int LINK_PERIOD_NS = 48;
  localparam int SPIKE_NS = 50;

  // A level must be seen on this many samples in a row to be taken.
  localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;

  // Number of bits in one byte on the bus, without the acknowledge slot.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : ira_pkg

`default_nettype wire

// File: hdl/ira_mode_mem.sv
`default_nettype none

// -----------------------------------------------------------------------------
// Storage of the mode registers, with a registered read port.
// -----------------------------------------------------------------------------
module ira_mode_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [ira_pkg::MEM_AW-1:0] waddr,
  input wire logic [ira_pkg::DATA_W-1:0] wdata,
  input wire logic [ira_pkg::MEM_AW-1:0] raddr,
  output logic [ira_pkg::DATA_W-1:0] rdata
);
  import ira_pkg::*;

  // One byte for every index of the read window.
  logic [DATA_W-1:0] mem_r [2**MEM_AW];

  // Writes store a byte; reset returns every byte to its start value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**MEM_AW; i++) begin
        mem_r[i] <= MEM_RESET;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // Read data leave through a register, one cycle after the address.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= MEM_RESET;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule : ira_mode_mem

`default_nettype wire

// File: hdl/ira_i2c_slave.sv
`default_nettype none

// Functional notes
// - Index names first register; data fill following.
// - Pointer advances after each accepted write byte.
// - Pointer wraps from 0x7F to zero.
// - Write to undefined index gets no acknowledge.
// - Read returns register chosen by the pointer.
// - Pointer advances after each transmitted byte.
// - No advance on entering read after write.
// - Indices 0x10 to 0x1F always return data.
// - Bus lines filtered by clocked spike suppressor.
// - Suppressor works for 8 to 40 MHz.
// - Pulses up to 50 ns are rejected.
// - Slow clock, short high: spikes read low.
// - Slow clock, short start hold: start missed.
// - Fast clock, wide spikes: false start/stop.
// - Address is 10011 plus two select pins.
// - Slave receiver and transmitter only, master frames.

// -----------------------------------------------------------------------------
// Register access slave on a two-wire bus, sampled by its own system clock.
// -----------------------------------------------------------------------------
module ira_i2c_slave (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic filt_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  input wire logic zero_flag_l,
  input wire logic zero_flag_r,
  output logic sda_o,
  output logic sda_oe_n,
  output logic upd_valid,
  output logic [ira_pkg::IDX_W-1:0] upd_index,
  output logic [ira_pkg::DATA_W-1:0] upd_data
);
  import ira_pkg::*;

  // Protocol states of the bus engine.
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_INDEX,
    S_WDATA,
    S_ACK,
    S_RDATA,
    S_MACK
  } ira_state_t;

  // ---------------------------------------------------------------------------
  // Reset release in both clock domains.
  // ---------------------------------------------------------------------------

  logic [1:0] mrst_sync_r; // Reset release chain on the main clock.
  logic [1:0] lrst_sync_r; // Reset release chain on the sampling clock.
  logic mrst_n; // Main clock domain reset.
  logic lrst_n; // Sampling clock domain reset.

  // Assert at once, release after two main clock edges.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mrst_sync_r <= 2'h0;
    end else begin
      mrst_sync_r <= {mrst_sync_r[0], 1'b1};
    end
  end

  // Assert at once, release after two sampling clock edges.
  always_ff @(posedge filt_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_sync_r <= 2'h0;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
    end
  end

  assign mrst_n = mrst_sync_r[1];
  assign lrst_n = lrst_sync_r[1];

  // ---------------------------------------------------------------------------
  // Input synchronisers and spike suppressor on the sampling clock.
  // ---------------------------------------------------------------------------

  logic [1:0] raw_in; // Bus lines as they arrive: bit 1 clock, bit 0 data.
  logic [1:0] sync1_r; // First synchroniser stage.
  logic [1:0] sync2_r; // Second synchroniser stage.
  logic [1:0] filt_r; // Filtered bus lines.
  logic [1:0] filt_q_r; // Filtered lines one sample earlier.
  logic scl_f; // Filtered clock line.
  logic sda_f; // Filtered data line.

  assign raw_in = {scl_i, sda_i};

  // Two flip-flops before any logic looks at the bus lines.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // One stability counter per line; a spike shorter than the window never
  // lasts long enough to change the filtered level.
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [1:0] cnt_r; // Samples in a row that differ from the filtered level.

    // Count disagreeing samples and take the new level once stable.
    always_ff @(posedge filt_clk or negedge lrst_n) begin
      if (!lrst_n) begin
        cnt_r <= 2'h0;
        filt_r[g] <= 1'b1;
      end else if (sync2_r[g] == filt_r[g]) begin
        cnt_r <= 2'h0;
      end else if (cnt_r == 2'(FILT_CYC - 1)) begin
        cnt_r <= 2'h0;
        filt_r[g] <= sync2_r[g];
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  // Keep the previous filtered levels for edge detection.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      filt_q_r <= 2'h3;
    end else begin
      filt_q_r <= filt_r;
    end
  end

  assign scl_f = filt_r[1];
  assign sda_f = filt_r[0];

  // Bus events seen through the filter.
  logic scl_rise; // Clock line went high.
  logic scl_fall; // Clock line went low.
  logic start_det; // Data fell while the clock was high.
  logic stop_det; // Data rose while the clock was high.

  assign scl_rise = scl_f & ~filt_q_r[1];
  assign scl_fall = ~scl_f & filt_q_r[1];
  assign start_det = scl_f & filt_q_r[1] & filt_q_r[0] & ~sda_f;
  assign stop_det = scl_f & filt_q_r[1] & ~filt_q_r[0] & sda_f;

  // Address select pins pass two flip-flops as well.
  logic [1:0] asel1_r; // First stage of the select pins.
  logic [1:0] asel2_r; // Second stage of the select pins.
  logic [1:0] zf1_r; // First stage of the zero flags.
  logic [1:0] zf2_r; // Second stage of the zero flags.

  // Bring pins and zero flags into the sampling clock domain.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      asel1_r <= 2'h0;
      asel2_r <= 2'h0;
      zf1_r <= 2'h0;
      zf2_r <= 2'h0;
    end else begin
      asel1_r <= {addr_select_hi, addr_select_lo};
      asel2_r <= asel1_r;
      zf1_r <= {zero_flag_l, zero_flag_r};
      zf2_r <= zf1_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus engine.
  // ---------------------------------------------------------------------------

  ira_state_t state_r; // Current protocol state.
  ira_state_t ret_r; // State to return to after an acknowledge slot.
  logic [3:0] bit_cnt_r; // Bits seen in the current byte.
  logic [7:0] shift_r; // Received byte, most significant bit first.
  logic [7:0] tx_r; // Byte being sent, most significant bit leading.
  logic mack_r; // Master acknowledged the last sent byte.
  logic [IDX_W-1:0] idx_r; // Index pointer.
  logic [DATA_W-1:0] mem_rdata; // Stored byte at the pointer.
  logic [DATA_W-1:0] rd_byte; // Byte to send for the current pointer.
  logic byte_end; // Falling clock closing a received byte.
  logic addr_match; // Received address is ours.
  logic wr_ok; // Pointer names a writable register.
  logic wr_now; // Store the received byte this cycle.

  assign byte_end = scl_fall && (bit_cnt_r == BITS_PER_BYTE) &&
                    (state_r == S_ADDR || state_r == S_INDEX || state_r == S_WDATA);
  assign addr_match = (shift_r[7:1] == {SLAVE_PREFIX, asel2_r});
  assign wr_ok = (idx_r >= WR_LO) && (idx_r <= WR_HI);
  assign wr_now = byte_end && (state_r == S_WDATA) && wr_ok;

  // Read byte: stored value, zero flags, or a fixed byte outside the window.
  always_comb begin
    if (idx_r == FLAG_IDX) begin
      rd_byte = {6'h00, zf2_r};
    end else if ((idx_r >= RD_WIN_LO) && (idx_r <= RD_WIN_HI)) begin
      rd_byte = mem_rdata;
    end else begin
      rd_byte = RD_OUTSIDE;
    end
  end

  // Framing follows the master; start and stop override any state.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_r <= S_IDLE;
      ret_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_det) begin
      // A repeated start also lands here and begins a new address.
      state_r <= S_ADDR;
      bit_cnt_r <= 4'h0;
    end else if (stop_det) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          bit_cnt_r <= 4'h0;
        end
        S_ADDR, S_INDEX, S_WDATA: begin
          if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            bit_cnt_r <= 4'h0;
            state_r <= S_ACK;
            if (state_r == S_ADDR) begin
              // Unknown address: stay off the bus until the next start.
              state_r <= addr_match ? S_ACK : S_IDLE;
              ret_r <= shift_r[0] ? S_RDATA : S_INDEX;
            end else if (state_r == S_INDEX) begin
              ret_r <= S_WDATA;
            end else begin
              state_r <= wr_ok ? S_ACK : S_IDLE;
              ret_r <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          // The acknowledge slot ends on the next falling clock.
          if (scl_fall) begin
            state_r <= ret_r;
            bit_cnt_r <= 4'h0;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h7) begin
              state_r <= S_MACK;
            end
          end
        end
        S_MACK: begin
          // Not acknowledged means last byte; wait for the stop.
          if (scl_fall) begin
            state_r <= mack_r ? S_RDATA : S_IDLE;
            bit_cnt_r <= 4'h0;
          end
        end
      endcase
    end
  end

  // Master answer is taken on the rising clock of its acknowledge slot.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      mack_r <= 1'b0;
    end else if (state_r == S_MACK && scl_rise) begin
      mack_r <= ~sda_f;
    end
  end

  // Index pointer: loaded by the index byte, advanced after each stored or sent data byte.
  // The add is seven bits wide, so 0x7F rolls over to zero.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      idx_r <= IDX_RESET;
    end else if (byte_end && state_r == S_INDEX) begin
      idx_r <= shift_r[6:0];
    end else if (wr_now) begin
      idx_r <= idx_r + 7'h01;
    end else if (state_r == S_MACK && scl_rise && !start_det && !stop_det) begin
      idx_r <= idx_r + 7'h01;
    end
    // Entering a read never moves the pointer.
  end

  // Data line drive: low for acknowledge and for zero bits, else released.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_oe_n <= 1'b1;
      tx_r <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_oe_n <= 1'b1;
    end else if (byte_end) begin
      sda_oe_n <= ~((state_r == S_ADDR && addr_match) || state_r == S_INDEX ||
                    (state_r == S_WDATA && wr_ok));
    end else if (scl_fall && ((state_r == S_ACK && ret_r == S_RDATA) ||
                              (state_r == S_MACK && mack_r))) begin
      sda_oe_n <= rd_byte[7];
      tx_r <= {rd_byte[6:0], 1'b0};
    end else if (scl_fall && state_r == S_ACK) begin
      sda_oe_n <= 1'b1;
    end else if (scl_fall && state_r == S_RDATA) begin
      sda_oe_n <= (bit_cnt_r == 4'h7) ? 1'b1 : tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end else if (scl_fall && state_r == S_MACK) begin
      sda_oe_n <= 1'b1;
    end
  end

  // The line is open drain: the driven level is always low.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Mode register storage, addressed by the low pointer bits.
  ira_mode_mem u_mem (
    .clk(filt_clk),
    .rst_n(lrst_n),
    .we(wr_now),
    .waddr(idx_r[MEM_AW-1:0]),
    .wdata(shift_r),
    .raddr(idx_r[MEM_AW-1:0]),
    .rdata(mem_rdata)
  );

  // ---------------------------------------------------------------------------
  // Write notification to the main clock domain.
  // ---------------------------------------------------------------------------

  logic wr_tgl_r; // Toggles on every stored byte.
  logic [IDX_W-1:0] wr_idx_r; // Index of the last stored byte.
  logic [DATA_W-1:0] wr_data_r; // Value of the last stored byte.

  // Hold the written word stable while the toggle crosses over.
  always_ff @(posedge filt_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      wr_tgl_r <= 1'b0;
      wr_idx_r <= IDX_RESET;
      wr_data_r <= MEM_RESET;
    end else if (wr_now) begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_idx_r <= idx_r;
      wr_data_r <= shift_r;
    end
  end

  logic [2:0] tgl_sync_r; // Toggle synchroniser plus edge stage.

  // Two flip-flops for the toggle, a third to find its change.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      tgl_sync_r <= 3'h0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], wr_tgl_r};
    end
  end

  // A toggle change captures the held word and pulses the valid flag.
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      upd_valid <= 1'b0;
      upd_index <= IDX_RESET;
      upd_data <= MEM_RESET;
    end else begin
      upd_valid <= tgl_sync_r[2] ^ tgl_sync_r[1];
      if (tgl_sync_r[2] ^ tgl_sync_r[1]) begin
        upd_index <= wr_idx_r;
        upd_data <= wr_data_r;
      end
    end
  end

  // The suppressor keeps the known weak spots of its kind: slow sampling
  // can read a spiked high as low or miss a short start, and fast sampling
  // can take a wide spike near a falling clock as start or stop.

endmodule : ira_i2c_slave

`default_nettype wire

// File: bench/ira_i2c_monitor.sv
`default_nettype none

// ----------------------------------------------------------------
// Port checker of the register access slave.
// ----------------------------------------------------------------
module ira_i2c_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic filt_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  input wire logic zero_flag_l,
  input wire logic zero_flag_r,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic upd_valid,
  input wire logic [ira_pkg::IDX_W-1:0] upd_index,
  input wire logic [ira_pkg::DATA_W-1:0] upd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import ira_pkg::*;

  // The drive only moves once the bus clock has been low for a while.
  a_drive_on_low: assert property (@(posedge filt_clk) disable iff (!arst_n)
    $changed(sda_oe_n) |-> !scl_i && !$past(scl_i, 3))
    else $error("Data drive changed while the bus clock was high.");
  // A steady high bus clock freezes the drive.
  a_oe_steady: assert property (@(posedge filt_clk) disable iff (!arst_n)
    scl_i [*3] |-> $stable(sda_oe_n))
    else $error("Data drive moved during a clock high phase.");
  // A low drive lasts at least nine sampling clock cycles.
  a_drive_hold: assert property (@(posedge filt_clk) disable iff (!arst_n)
    $fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("Data drive released too early.");
  // The line is released again within 1000 sampling clock cycles of being pulled low.
  a_drive_bounded: assert property (@(posedge filt_clk) disable iff (!arst_n)
    $fell(sda_oe_n) |-> ##[1:1000] $rose(sda_oe_n))
    else $error("Data drive held too long.");
  // The pin is open drain: only a low level is ever driven.
  a_sda_o_low: assert property (@(posedge filt_clk) disable iff (!arst_n)
    sda_o == 1'b0)
    else $error("Data drive value is not low.");
  // Only writable indices are ever reported as stored.
  a_upd_range: assert property (@(posedge mclk) disable iff (!arst_n)
    upd_valid |-> upd_index >= WR_LO && upd_index <= WR_HI)
    else $error("Store reported at an undefined index.");
  // One store gives one pulse, and stores lie far apart.
  a_upd_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    upd_valid |=> !upd_valid [*8])
    else $error("Store pulse too long or repeated.");
  // Reported index and value stand between pulses.
  a_upd_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !upd_valid |-> $stable(upd_index) && $stable(upd_data))
    else $error("Store report changed without a pulse.");

  c_upd: cover property (@(posedge mclk) disable iff (!arst_n) upd_valid);
  c_top: cover property (@(posedge mclk) disable iff (!arst_n) upd_valid && upd_index == WR_HI);
  c_ack: cover property (@(posedge filt_clk) disable iff (!arst_n) $fell(sda_oe_n));
endmodule : ira_i2c_monitor

`default_nettype wire

// File: bench/ira_i2c_master.sv
`default_nettype none

// ----------------------------------------------------------------
// Behavioural bus master; the line idles high and only the clock
// is driven push-pull, data is released to the pull-up.
// ----------------------------------------------------------------
module ira_i2c_master (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 500; // Quarter bit, well above the filter delay.

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bit slot: data set while the clock is low, sampled mid-high.
  task automatic slot(input logic b, output logic r);
    sda_low = !b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask : slot

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start

  // Stop: data rises while the clock is high; the clock then stands.
  task automatic stop();
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask : stop

  // A clock glitch as long as the longest pulse that must be rejected.
  task automatic spike();
    scl = 1'b1;
    #50 scl = 1'b0;
    #QTR;
  endtask : spike

  // Sends a byte MSB first and returns the acknowledge.
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(b[i], r);
    end
    slot(1'b1, r);
    ack = !r;
  endtask : send

  // Receives a byte; the last one is answered with a not-acknowledge.
  task automatic recv(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, b[i]);
    end
    slot(!more, r);
  endtask : recv
endmodule : ira_i2c_master

`default_nettype wire

// File: bench/ira_i2c_register_access_slave_test.sv
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench of the register access slave.
// ----------------------------------------------------------------
module ira_i2c_register_access_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ira_pkg::*;

  logic mclk, filt_clk, arst_n, scl, sda_low, sda, zl, zr, sda_o, sda_oe_n, upd_valid;
  logic [IDX_W-1:0] upd_index;
  logic [DATA_W-1:0] upd_data;
  logic [14:0] upd_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic sel_hi = 1'b1; // Address select pins, moved by one scenario.
  logic sel_lo = 1'b0;

  // Pull-up wire: low when either party pulls it.
  assign sda = !(sda_low || (!sda_oe_n && !sda_o));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = !mclk;
  end
  initial begin
    filt_clk = 1'b0;
    #7;
    forever #24 filt_clk = !filt_clk;
  end

  ira_i2c_master mst (.scl(scl), .sda_low(sda_low), .sda(sda));

  ira_i2c_slave DUT (.mclk(mclk), .arst_n(arst_n), .filt_clk(filt_clk), .scl_i(scl),
    .sda_i(sda), .addr_select_hi(sel_hi), .addr_select_lo(sel_lo), .zero_flag_l(zl),
    .zero_flag_r(zr), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .upd_valid(upd_valid),
    .upd_index(upd_index), .upd_data(upd_data));

  // Collects every store report as it is pulsed.
  always @(posedge mclk) begin
    if (upd_valid === 1'b1) begin
      upd_q.push_back({upd_index, upd_data});
    end
  end

  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] adr(input logic rd, input logic mine);
    return {SLAVE_PREFIX, sel_hi, sel_lo ^ !mine, rd};
  endfunction : adr

  // Waits a bounded time for one store report and compares it.
  task automatic get_upd(input logic [6:0] idx, input logic [7:0] d);
    logic [14:0] e;
    for (int n = 0; n < 300 && upd_q.size() == 0; n++) @(posedge mclk);
    e = (upd_q.size() > 0) ? upd_q.pop_front() : 15'h7FFF;
    chk("store index", {9'h000, idx}, {9'h000, e[14:8]});
    chk("store data", {8'h00, d}, {8'h00, e[7:0]});
  endtask : get_upd

  // Multi-byte write, ending on an undefined index.
  task automatic t_write();
    logic a;
    mst.start();
    mst.send(adr(1'b0, 1'b1), a); chk("address ack", 1, a);
    mst.send(8'h14, a); chk("index ack", 1, a);
    mst.send(8'hA1, a); chk("data ack", 1, a);
    mst.send(8'h5C, a); chk("second data ack", 1, a);
    mst.send(8'h77, a); chk("undefined nack", 0, a);
    mst.stop();
    get_upd(7'h14, 8'hA1);
    get_upd(7'h15, 8'h5C);
    chk("extra stores", 0, upd_q.size());
  endtask : t_write

  // Index write, repeated start, read two bytes; then read on.
  task automatic t_read();
    logic a;
    logic [7:0] d;
    mst.start();
    mst.send(adr(1'b0, 1'b1), a);
    mst.send(8'h14, a);
    mst.start();
    mst.send(adr(1'b1, 1'b1), a); chk("read address ack", 1, a);
    mst.recv(1'b1, d); chk("first read", 16'h00A1, d);
    mst.recv(1'b0, d); chk("second read", 16'h005C, d);
    mst.stop();
    mst.start();
    mst.send(adr(1'b1, 1'b1), a);
    mst.recv(1'b0, d); chk("flag read", {14'h0000, zl, zr}, d);
    mst.stop();
  endtask : t_read

  // Another address is ignored; moving a select pin moves the address.
  task automatic t_wrong();
    logic a;
    mst.start();
    mst.send(adr(1'b0, 1'b0), a); chk("foreign address", 0, a);
    mst.stop();
    @(posedge mclk);
    sel_lo <= 1'b1;
    repeat (4) @(posedge mclk);
    mst.start();
    mst.send(8'h9E, a); chk("moved address", 1, a);
    mst.stop();
    mst.start();
    mst.send(8'h9C, a); chk("old address", 0, a);
    mst.stop();
    @(posedge mclk);
    sel_lo <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : t_wrong

  // A short clock glitch before a data byte must not shift it.
  task automatic t_spike();
    logic a;
    mst.start();
    mst.send(adr(1'b0, 1'b1), a);
    mst.send(8'h10, a);
    mst.spike();
    mst.send(8'h3C, a); chk("ack after glitch", 1, a);
    mst.stop();
    get_upd(7'h10, 8'h3C);
  endtask : t_spike

  // Long read from the top index round to the stored bytes.
  task automatic t_wrap();
    logic a;
    logic [7:0] d;
    mst.start();
    mst.send(adr(1'b0, 1'b1), a);
    mst.send(8'h7F, a);
    mst.start();
    mst.send(adr(1'b1, 1'b1), a);
    for (int k = 0; k < 23; k++) begin
      mst.recv(k < 22, d);
      if (k == 0) chk("outside read", {8'h00, RD_OUTSIDE}, d);
      if (k == 17) chk("wrapped read 10", 16'h003C, d);
      if (k == 21) chk("wrapped read 14", 16'h00A1, d);
      if (k == 22) chk("wrapped read 15", 16'h005C, d);
    end
    mst.stop();
  endtask : t_wrap

  task automatic conclude();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    arst_n = 1'b0;
    zl = 1'b1;
    zr = 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    t_write();
    t_read();
    t_wrong();
    t_spike();
    t_wrap();
    conclude();
  end
endmodule : ira_i2c_register_access_slave_test

bind ira_i2c_slave ira_i2c_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .filt_clk(filt_clk),
  .scl_i(scl_i), .sda_i(sda_i), .addr_select_hi(addr_select_hi),
  .addr_select_lo(addr_select_lo), .zero_flag_l(zero_flag_l), .zero_flag_r(zero_flag_r),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .upd_valid(upd_valid), .upd_index(upd_index),
  .upd_data(upd_data));

`default_nettype wire
